// file: design/scr_system_control.sv
/*
 * System control register: one 8-bit register that steers pin functions,
 * interrupt mode, nmi edge, the shared peripheral address window and the
 * on-chip ram enable, plus the extended-mode control bit it depends on.
 * Assumes all inputs are synchronous to clk_i and that rst_i covers both
 * the external reset pin and the watchdog overflow reset.
 */
// What this block does
// - host pin location bit enables second chip-select; gate a20 enable input picks its pin
// - strobe bit 0: in extended mode, pin strobes every external access
// - strobe bit 1: in extended mode, pin strobes only io window
// - irq mode 00/01 only; upper bit read-only
// - reset source flag: 0 watchdog, 1 external
// - nmi edge bit: 0 falling, 1 rising
// - window bit 0 routes shared ranges to timers
// - window bit 1 routes shared ranges to host
// - ram enable bit enables on-chip ram
// - ram enable reloads when reset releases
// - extended mode forced in mode 1, else writable
`timescale 1ns/1ns
module scr_system_control (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wdt_reset_cause_i,
    input  wire logic [1:0]                mode_pins_i,
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_we_i,
    input  wire logic                      reg_re_i,
    output logic      [7:0]                reg_rdata_o,
    input  wire logic                      gate_a20_enable_bit_i,
    output logic                           host_cs2_primary_o,
    output logic                           host_cs2_alternate_o,
    input  wire scr_pkg::scr_cpu_access_t  cpu_access_i,
    output logic                           strobe_pin_n_o,
    output scr_pkg::scr_window_sel_t       window_sel_o,
    output logic      [1:0]                irq_mode_o,
    input  wire logic                      nmi_pin_i,
    output logic                           nmi_request_o,
    output logic                           ram_enable_o,
    output logic                           extended_mode_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // inclusive range check, shared by the io window and both shared ranges
    function automatic logic scr_in_range(input logic [15:0] a,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        scr_in_range = (a >= lo) && (a <= hi);
    endfunction : scr_in_range

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic        host_pin_loc_q;
    logic        io_strobe_q;
    logic        irq_mode_lo_q;
    logic        rst_source_q;
    logic        nmi_edge_q;
    logic        host_window_q;
    logic        ram_enable_q;
    logic        ext_mode_q;
    logic [1:0]  mode_pins_q;
    logic        rst_dly_q;
    logic        nmi_prev_q;
    logic        nmi_req_q;
    logic [7:0]  rdata_q;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire         hit_sys      = (reg_addr_i == scr_pkg::OFS_SYSCTRL);
    wire         hit_mode     = (reg_addr_i == scr_pkg::OFS_MODECTRL);
    wire         wr_sys       = reg_we_i && hit_sys;
    wire         wr_mode      = reg_we_i && hit_mode;
    wire         mode1_fixed  = (mode_pins_q == scr_pkg::MCU_MODE1);
    wire         ext_mode     = mode1_fixed || ext_mode_q;
    wire         rst_release  = rst_dly_q && !rst_i;

    // live register images; only the fixed upper irq bit and the zero pad are constants
    wire  [7:0]  sys_image    = {host_pin_loc_q,
                                 io_strobe_q,
                                 scr_pkg::IRQ_MODE_HI_FIX,
                                 irq_mode_lo_q,
                                 rst_source_q,
                                 nmi_edge_q,
                                 host_window_q,
                                 ram_enable_q};
    wire  [7:0]  mode_image   = {ext_mode, 5'h00, mode_pins_q};
    wire  [7:0]  rd_mux       = hit_sys  ? sys_image  :
                                hit_mode ? mode_image : 8'h00;

    // ------------------------------------------------------------------
    // writable control bits of system_control_reg
    // ------------------------------------------------------------------
    // the upper irq mode bit and the reset source bit have no write path
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            host_pin_loc_q <= scr_pkg::RST_HOST_PIN_LOC;
            io_strobe_q    <= scr_pkg::RST_IO_STROBE;
            irq_mode_lo_q  <= scr_pkg::RST_IRQ_MODE_LO;
            nmi_edge_q     <= scr_pkg::RST_NMI_EDGE;
            host_window_q  <= scr_pkg::RST_HOST_WINDOW;
        end
        else if (wr_sys)
        begin
            host_pin_loc_q <= reg_wdata_i[scr_pkg::BIT_HOST_PIN_LOC];
            io_strobe_q    <= reg_wdata_i[scr_pkg::BIT_IO_STROBE];
            irq_mode_lo_q  <= reg_wdata_i[scr_pkg::BIT_IRQ_MODE_LO];
            nmi_edge_q     <= reg_wdata_i[scr_pkg::BIT_NMI_EDGE];
            host_window_q  <= reg_wdata_i[scr_pkg::BIT_HOST_WINDOW];
        end
    end

    // ------------------------------------------------------------------
    // reset source and mode pin capture
    // ------------------------------------------------------------------
    // both are sampled while reset is held, so the last sample before the
    // release is what software sees; software cannot alter either
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rst_source_q <= wdt_reset_cause_i ? scr_pkg::SRC_WATCHDOG
                                              : scr_pkg::SRC_EXTERNAL;
            mode_pins_q  <= mode_pins_i;
        end
    end

    // ------------------------------------------------------------------
    // ram enable with reload on reset release
    // ------------------------------------------------------------------
    // the release cycle forces the reset value again, so a write that lands
    // in that very cycle is dropped in favour of the documented reload
    always_ff @(posedge clk_i)
    begin
        rst_dly_q <= rst_i;
        if (rst_i || rst_release)
            ram_enable_q <= scr_pkg::RST_RAM_ENABLE;
        else if (wr_sys)
            ram_enable_q <= reg_wdata_i[scr_pkg::BIT_RAM_ENABLE];
    end

    // ------------------------------------------------------------------
    // extended mode bit
    // ------------------------------------------------------------------
    // in mode 1 the flop still exists but is masked by mode1_fixed above
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ext_mode_q <= scr_pkg::RST_EXT_MODE;
        else if (wr_mode && !mode1_fixed)
            ext_mode_q <= reg_wdata_i[scr_pkg::BIT_EXT_MODE];
    end

    // ------------------------------------------------------------------
    // nmi edge detection
    // ------------------------------------------------------------------
    // the previous level is loaded from the pin during reset so the release
    // never looks like an edge
    wire nmi_rise = nmi_pin_i && !nmi_prev_q;
    wire nmi_fall = !nmi_pin_i && nmi_prev_q;
    always_ff @(posedge clk_i)
    begin
        nmi_prev_q <= nmi_pin_i;
        if (rst_i)
            nmi_req_q <= 1'b0;
        else
            nmi_req_q <= nmi_edge_q ? nmi_rise : nmi_fall;
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    // data stand for exactly one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= 8'h00;
        else
            rdata_q <= reg_re_i ? rd_mux : 8'h00;
    end

    // ------------------------------------------------------------------
    // pin and address steering
    // ------------------------------------------------------------------
    wire io_win_hit  = scr_in_range(cpu_access_i.addr, scr_pkg::IO_WIN_LO,
                                    scr_pkg::IO_WIN_HI);
    wire shared_hit  = scr_in_range(cpu_access_i.addr, scr_pkg::SHARED_A_LO,
                                    scr_pkg::SHARED_A_HI) ||
                       scr_in_range(cpu_access_i.addr, scr_pkg::SHARED_B_LO,
                                    scr_pkg::SHARED_B_HI);
    wire as_strobe   = cpu_access_i.valid && cpu_access_i.external;
    wire ios_strobe  = cpu_access_i.valid && io_win_hit;
    wire strobe_act  = ext_mode && (io_strobe_q ? ios_strobe : as_strobe);

    // strobe is combinational so it frames the access in the same cycle
    assign strobe_pin_n_o       = !strobe_act;
    assign window_sel_o.timer   = cpu_access_i.valid && shared_hit
                                  && !host_window_q;
    assign window_sel_o.host    = cpu_access_i.valid && shared_hit
                                  && host_window_q;
    // the second chip-select is driven only when the host pin bit is set; the gate a20 enable input picks the pin
    assign host_cs2_primary_o   = host_pin_loc_q && !gate_a20_enable_bit_i;
    assign host_cs2_alternate_o = host_pin_loc_q && gate_a20_enable_bit_i;
    assign irq_mode_o           = {scr_pkg::IRQ_MODE_HI_FIX, irq_mode_lo_q};
    assign nmi_request_o        = nmi_req_q;
    assign ram_enable_o         = ram_enable_q;
    assign extended_mode_o      = ext_mode;
    assign reg_rdata_o          = rdata_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    host_pin_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (host_cs2_primary_o || host_cs2_alternate_o) == host_pin_loc_q
        && !(host_cs2_primary_o && host_cs2_alternate_o))
        else $error("second chip-select routing wrong");

    addr_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ext_mode && !io_strobe_q && cpu_access_i.valid
         && cpu_access_i.external) |-> !strobe_pin_n_o)
        else $error("address strobe missing on external access");

    io_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (io_strobe_q && !strobe_pin_n_o) |->
        (io_win_hit && cpu_access_i.valid && ext_mode))
        else $error("io strobe outside io window");

    irq_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_sys |=> irq_mode_o == {1'b0, $past(reg_wdata_i[4])})
        else $error("irq mode not as written or upper bit set");

    rst_source_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> reg_rdata_o == 8'h00
        ##0 rst_source_q == !$past(wdt_reset_cause_i))
        else $error("reset source flag wrong after reset");

    nmi_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!nmi_edge_q && $past(nmi_edge_q) == 1'b0 && $fell(nmi_pin_i)
         && !$past(rst_i)) |=> nmi_request_o)
        else $error("falling nmi edge not requested");

    nmi_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(nmi_pin_i) |=> !nmi_request_o)
        else $error("nmi request without an edge");

    window_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cpu_access_i.valid && shared_hit) |->
        (window_sel_o.host == host_window_q && window_sel_o.timer != host_window_q))
        else $error("shared window routed wrongly");

    ram_reload_a: assert property (@(posedge clk_i)
        (rst_dly_q && !rst_i) |=> ram_enable_o)
        else $error("ram enable not reloaded at reset release");

    ext_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode1_fixed |-> extended_mode_o [*2])
        else $error("extended mode not held in mode 1");

    ro_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_sys |=> $stable(rst_source_q) && !irq_mode_o[1])
        else $error("read-only bit changed by a write");

    read_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (reg_re_i && hit_sys) |=> reg_rdata_o[0] == ram_enable_o
        ##1 ($past(reg_re_i) || reg_rdata_o == 8'h00))
        else $error("read data wrong or held too long");

endmodule : scr_system_control

// file: design/scr_pkg.sv
/*
 * Shared constants and carriers for the system control register block:
 * register offsets, bit positions, reset values, address windows and the
 * structs that carry a cpu access and the window selects.
 * Assumes a 16-bit view of the cpu address; the upper byte (FF) of the
 * advanced-mode address space is decoded elsewhere.
 */
package scr_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int unsigned  ADDR_W       = 8;
    localparam int unsigned  DATA_W       = 8;
    localparam logic [7:0]   OFS_SYSCTRL  = 8'h00;
    localparam logic [7:0]   OFS_MODECTRL = 8'h01;

    // ------------------------------------------------------------------
    // bit positions of system_control_reg and mode_control_reg
    // ------------------------------------------------------------------
    localparam int unsigned  BIT_HOST_PIN_LOC = 7;
    localparam int unsigned  BIT_IO_STROBE    = 6;
    localparam int unsigned  BIT_IRQ_MODE_HI  = 5;
    localparam int unsigned  BIT_IRQ_MODE_LO  = 4;
    localparam int unsigned  BIT_RST_SOURCE   = 3;
    localparam int unsigned  BIT_NMI_EDGE     = 2;
    localparam int unsigned  BIT_HOST_WINDOW  = 1;
    localparam int unsigned  BIT_RAM_ENABLE   = 0;
    localparam int unsigned  BIT_EXT_MODE     = 7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic         RST_HOST_PIN_LOC = 1'b0;
    localparam logic         RST_IO_STROBE    = 1'b0;
    localparam logic         RST_IRQ_MODE_LO  = 1'b0;
    localparam logic         RST_NMI_EDGE     = 1'b0;
    localparam logic         RST_HOST_WINDOW  = 1'b0;
    localparam logic         RST_RAM_ENABLE   = 1'b1;
    localparam logic         RST_EXT_MODE     = 1'b0;
    localparam logic         SRC_WATCHDOG     = 1'b0;
    localparam logic         SRC_EXTERNAL     = 1'b1;

    // ------------------------------------------------------------------
    // codes and address windows
    // ------------------------------------------------------------------
    localparam logic [1:0]   MCU_MODE1        = 2'h1;
    localparam logic         IRQ_MODE_HI_FIX  = 1'b0;
    localparam logic [15:0]  IO_WIN_LO        = 16'hF000;
    localparam logic [15:0]  IO_WIN_HI        = 16'hF7FF;
    localparam logic [15:0]  SHARED_A_LO      = 16'hFFF0;
    localparam logic [15:0]  SHARED_A_HI      = 16'hFFF7;
    localparam logic [15:0]  SHARED_B_LO      = 16'hFFFC;
    localparam logic [15:0]  SHARED_B_HI      = 16'hFFFF;

    typedef struct packed {
        logic        valid;
        logic        external;
        logic [15:0] addr;
    } scr_cpu_access_t;

    typedef struct packed {
        logic timer;
        logic host;
    } scr_window_sel_t;

endpackage : scr_pkg

// file: bench/tb.sv
/*
 * Self-checking bench for the system control register block. It covers register
 * access, pin steering, window routing, nmi edges and both reset sources.
 * Assumes the block stands alone on one 100 MHz clock with a synchronous reset.
 */
`timescale 1ns/1ns
module tb;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic                      clk_i;
    logic                      rst_i;
    logic                      wdt_reset_cause_i;
    logic [1:0]                mode_pins_i;
    logic [7:0]                reg_addr_i;
    logic [7:0]                reg_wdata_i;
    logic                      reg_we_i;
    logic                      reg_re_i;
    logic [7:0]                reg_rdata_o;
    logic                      gate_a20_enable_bit_i;
    logic                      host_cs2_primary_o;
    logic                      host_cs2_alternate_o;
    scr_pkg::scr_cpu_access_t  cpu_access_i;
    logic                      strobe_pin_n_o;
    scr_pkg::scr_window_sel_t  window_sel_o;
    logic [1:0]                irq_mode_o;
    logic                      nmi_pin_i;
    logic                      nmi_request_o;
    logic                      ram_enable_o;
    logic                      extended_mode_o;
    int                        error_cnt = 0;
    int                        tests_run = 0;
    int                        cyc = 0;
    logic [7:0]                sys_m;
    logic                      ext_m;
    logic [7:0]                rd_v;
    logic [15:0]               corners [11] = '{16'hEFFF, 16'hF000, 16'hF7FF, 16'hF800,
        16'hFFEF, 16'hFFF0, 16'hFFF7, 16'hFFF8, 16'hFFFB, 16'hFFFC, 16'hFFFF};

    scr_system_control dut (.clk_i(clk_i), .rst_i(rst_i), .wdt_reset_cause_i(wdt_reset_cause_i),
        .mode_pins_i(mode_pins_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .gate_a20_enable_bit_i(gate_a20_enable_bit_i), .host_cs2_primary_o(host_cs2_primary_o),
        .host_cs2_alternate_o(host_cs2_alternate_o), .cpu_access_i(cpu_access_i),
        .strobe_pin_n_o(strobe_pin_n_o), .window_sel_o(window_sel_o), .irq_mode_o(irq_mode_o),
        .nmi_pin_i(nmi_pin_i), .nmi_request_o(nmi_request_o), .ram_enable_o(ram_enable_o),
        .extended_mode_o(extended_mode_o));

    // free-running clock, 10 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("wrong value at %0t: run did not finish", $time);
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // reset is held ten cycles; first request waits one spare cycle after release
    task automatic do_reset(input logic wdt, input logic [1:0] mode);
        @(posedge clk_i);
        rst_i             <= 1'b1;
        wdt_reset_cause_i <= wdt;
        mode_pins_i       <= mode;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        sys_m = wdt ? 8'h01 : 8'h09;
        ext_m = (mode == scr_pkg::MCU_MODE1);
    endtask : do_reset

    // write: one strobe cycle; model keeps only the writable bits
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_we_i    <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        if (a == scr_pkg::OFS_SYSCTRL)
            sys_m = (d & 8'hD7) | (sys_m & 8'h08);
        if (a == scr_pkg::OFS_MODECTRL && mode_pins_i != scr_pkg::MCU_MODE1)
            ext_m = d[7];
    endtask : wr

    // read: data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i   <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1;
        rd_v = reg_rdata_o;
    endtask : rd

    task automatic sys_check();
        logic a;
        a = gate_a20_enable_bit_i;
        rd(scr_pkg::OFS_SYSCTRL);
        chk(rd_v, sys_m, "system reg");
        chk(irq_mode_o, {1'b0, sys_m[4]}, "irq mode");
        chk(ram_enable_o, sys_m[0], "ram enable");
        chk({host_cs2_primary_o, host_cs2_alternate_o}, {sys_m[7] & ~a, sys_m[7] & a}, "cs2");
        chk(extended_mode_o, ext_m, "ext mode");
    endtask : sys_check

    // combinational strobe and window answers, checked in the same cycle
    task automatic acc(input logic v, input logic e, input logic [15:0] a);
        logic io;
        logic sh;
        @(posedge clk_i);
        cpu_access_i <= {v, e, a};
        #1;
        io = v && a >= scr_pkg::IO_WIN_LO && a <= scr_pkg::IO_WIN_HI;
        sh = v && ((a >= scr_pkg::SHARED_A_LO && a <= scr_pkg::SHARED_A_HI)
            || (a >= scr_pkg::SHARED_B_LO && a <= scr_pkg::SHARED_B_HI));
        chk(strobe_pin_n_o, !(ext_m && (sys_m[6] ? io : v && e)), "strobe");
        chk(window_sel_o, {sh & ~sys_m[1], sh & sys_m[1]}, "window");
    endtask : acc

    task automatic nmi_try(input logic lvl, input logic exp);
        @(posedge clk_i);
        nmi_pin_i <= lvl;
        @(posedge clk_i);
        #1;
        chk(nmi_request_o, exp, "nmi pulse");
        @(posedge clk_i);
        #1;
        chk(nmi_request_o, 1'b0, "nmi end");
    endtask : nmi_try

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        wdt_reset_cause_i = 1'b0;
        mode_pins_i = 2'h2;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_we_i = 1'b0;
        reg_re_i = 1'b0;
        gate_a20_enable_bit_i = 1'b0;
        cpu_access_i = '0;
        nmi_pin_i = 1'b1;
        void'($urandom(15));
        do_reset(1'b0, 2'h2);
        sys_check();
        rd(scr_pkg::OFS_MODECTRL);
        chk(rd_v, 8'h02, "mode reg");
        $display("test reset values done");
        // random writes with the all-ones and all-zeros corners first
        for (int i = 0; i < 18; i++)
        begin
            gate_a20_enable_bit_i <= 1'($urandom);
            wr(scr_pkg::OFS_SYSCTRL, i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom));
            sys_check();
        end
        $display("test register writes done");
        wr(8'h02, 8'hFF);
        rd(8'h02);
        chk(rd_v, 8'h00, "unmapped");
        @(posedge clk_i);
        #1;
        chk(reg_rdata_o, 8'h00, "read data hold");
        sys_check();
        $display("test unmapped done");
        // every mix of extended mode, strobe select and window select
        for (int m = 0; m < 8; m++)
        begin
            wr(scr_pkg::OFS_MODECTRL, {m[2], 7'h00});
            wr(scr_pkg::OFS_SYSCTRL, {1'b0, m[1], 4'h0, m[0], 1'b1});
            rd(scr_pkg::OFS_MODECTRL);
            chk(rd_v, {ext_m, 5'h00, mode_pins_i}, "mode reg");
            foreach (corners[k])
            begin
                acc(1'b1, 1'b1, corners[k]);
                acc(1'b1, 1'b0, corners[k]);
            end
            repeat (6) acc(1'($urandom), 1'($urandom), 16'($urandom));
        end
        $display("test strobe and window done");
        wr(scr_pkg::OFS_SYSCTRL, 8'h01);
        nmi_try(1'b0, 1'b1);
        nmi_try(1'b1, 1'b0);
        wr(scr_pkg::OFS_SYSCTRL, 8'h05);
        nmi_try(1'b0, 1'b0);
        nmi_try(1'b1, 1'b1);
        $display("test nmi edges done");
        wr(scr_pkg::OFS_SYSCTRL, 8'h00);
        sys_check();
        do_reset(1'b0, 2'h3);
        chk(ram_enable_o, 1'b1, "ram reload");
        sys_check();
        $display("test ram reload done");
        do_reset(1'b1, 2'h1);
        sys_check();
        wr(scr_pkg::OFS_MODECTRL, 8'h00);
        rd(scr_pkg::OFS_MODECTRL);
        chk(rd_v, 8'h81, "mode 1 reg");
        acc(1'b1, 1'b1, 16'h1234);
        $display("test watchdog reset done");
        end_sim();
    end
endmodule : tb
